// ---- rtl/acs_params.svh ----
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define ACS_CTRL_ADDR         8'hc5
`define ACS_RESULT_HIGH_ADDR  8'hc7

// ****************************************************************
// control register fields
// ****************************************************************
`define ACS_RES_LO_MSB        7
`define ACS_RES_LO_LSB        6
`define ACS_EXT_EN_BIT        5
`define ACS_DONE_BIT          4
`define ACS_BUSY_BIT          3
`define ACS_CHAN_MSB          2
`define ACS_CHAN_LSB          0
`define ACS_CTRL_RESET        8'h00
`define ACS_RESULT_RESET      10'h000

// ****************************************************************
// timing in clocks and machine cycles
// ****************************************************************
`define ACS_CLKS_PER_MCYCLE   12
`define ACS_MCYCLE_LAST       4'(`ACS_CLKS_PER_MCYCLE - 1)
`define ACS_CONV_MCYCLES      50
`define ACS_INIT_MCYCLES      2
`define ACS_SAMPLE_MCYCLES    8
`define ACS_MCYCLES_PER_BIT   4
`define ACS_INIT_END          6'(`ACS_INIT_MCYCLES - 1)
`define ACS_SAMPLE_END        6'(`ACS_INIT_MCYCLES + `ACS_SAMPLE_MCYCLES - 1)
`define ACS_LAST_MCYCLE       6'(`ACS_CONV_MCYCLES - 1)
`define ACS_BIT_LAST_PHASE    2'(`ACS_MCYCLES_PER_BIT - 1)

`endif

// ---- rtl/acs_pkg.sv ----
package acs_pkg;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ACS_IDLE    = 2'b00,
        ACS_INIT    = 2'b01,
        ACS_SAMPLE  = 2'b10,
        ACS_CONVERT = 2'b11
    } acs_state_e;

    typedef logic [9:0] acs_result_t;
    typedef logic [2:0] acs_chan_t;

endpackage

// ---- rtl/acs_sequencer.sv ----
// Operation
// - one of eight inputs is muxed to a converter giving ten result bits.
// - start to completion flag takes exactly fifty machine cycles.
// - control bits 2..0 form the binary channel number, bit 2 most significant.
// - result upper eight bits to result-high, low two bits to control bits 7..6.
// - further start requests never disturb a running conversion.
// - stored result does not change while completion flag is set.
// - starts arriving while completion or busy flag is set are dropped.
// - entering idle or power-down aborts a running conversion.
// - a completed result with its flag survives idle mode intact.
// - pin rising edge seen at machine cycle end, conversion starts next cycle.
// - software start begins at the machine cycle after the writing instruction.
// - two initiation cycles; busy set after first, sampling after second.
// - selected input sampled for eight machine cycles.
// - each result bit takes four machine cycles.
// - external start enable bit 5 allows pin starts; software starts always allowed.
// - completion flag bit 4 set by hardware, cleared only by software.
// - busy bit 3 set by start, held during conversion, cleared with completion.
// - channel field changes only while completion and busy flags are low.
// - clearing completion and setting busy in one write starts a new conversion.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "acs_params.svh"

module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        external_start_pin,
    input  wire logic        comparator_high,
    input  wire logic        idle_mode,
    input  wire logic        power_down_mode,
    output logic      [2:0]  channel_select,
    output logic             sample_enable,
    output logic      [9:0]  dac_code,
    output logic             conversion_done_flag,
    output logic             busy_start_bit
);

    // ************************************************************
    // declarations
    // ************************************************************
    acs_state_e  state;
    logic [3:0]  div_count;
    logic        mc_tick;
    logic [5:0]  conv_cycle;
    logic [1:0]  bit_phase;
    logic [9:0]  trial_mask;
    logic [9:0]  sar;
    logic [9:0]  next_sar;
    logic [7:0]  result_high_reg;
    logic [1:0]  result_low;
    logic        external_start_enable;
    logic        start_ff1;
    logic        start_ff2;
    logic        start_ff3;
    logic        start_level;
    logic        start_level_d;
    logic        start_rise;
    logic        ext_edge_seen;
    logic        ext_request;
    logic        cmp_ff1;
    logic        cmp_ff2;
    logic        cmp_ff3;
    logic        cmp_level;
    logic        sw_start_pending;
    logic        wr_ctrl;
    logic        done_clear;
    logic        sw_start_accept;
    logic        low_power;
    logic        start_now;
    logic        done_set;
    logic        bit_end;
    logic [5:0]  tick_since_start;

    // ************************************************************
    // machine cycle divider
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_count <= 4'h0;
        end else if (div_count == `ACS_MCYCLE_LAST) begin
            div_count <= 4'h0;
        end else begin
            div_count <= div_count + 4'h1;
        end
    end

    assign mc_tick = (div_count == `ACS_MCYCLE_LAST);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            start_ff1     <= 1'b0;
            start_ff2     <= 1'b0;
            start_ff3     <= 1'b0;
            start_level   <= 1'b0;
            start_level_d <= 1'b0;
        end else begin
            start_ff1     <= external_start_pin;
            start_ff2     <= start_ff1;
            start_ff3     <= start_ff2;
            if (start_ff2 == start_ff3) begin
                start_level <= start_ff3;
            end
            start_level_d <= start_level;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmp_ff1   <= 1'b0;
            cmp_ff2   <= 1'b0;
            cmp_ff3   <= 1'b0;
            cmp_level <= 1'b0;
        end else begin
            cmp_ff1 <= comparator_high;
            cmp_ff2 <= cmp_ff1;
            cmp_ff3 <= cmp_ff2;
            if (cmp_ff2 == cmp_ff3) begin
                cmp_level <= cmp_ff3;
            end
        end
    end

    assign start_rise = start_level & ~start_level_d;

    // ************************************************************
    // external start edge capture
    // ************************************************************
    // edge held until the end of the current machine cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext_edge_seen <= 1'b0;
        end else if (mc_tick) begin
            ext_edge_seen <= 1'b0;
        end else if (start_rise) begin
            ext_edge_seen <= 1'b1;
        end
    end

    assign ext_request = mc_tick & (ext_edge_seen | start_rise)
                       & external_start_enable;

    // ************************************************************
    // start arbitration
    // ************************************************************
    assign low_power       = idle_mode | power_down_mode;
    assign wr_ctrl         = reg_wr & (reg_addr == `ACS_CTRL_ADDR);
    assign done_clear      = wr_ctrl & ~reg_wdata[`ACS_DONE_BIT];
    // a write that clears the flag and sets busy still starts
    assign sw_start_accept = wr_ctrl & reg_wdata[`ACS_BUSY_BIT]
                           & ~busy_start_bit & (state == ACS_IDLE)
                           & (~conversion_done_flag | done_clear)
                           & ~done_set & ~low_power;
    assign start_now       = mc_tick & (state == ACS_IDLE) & ~low_power
                           & ~conversion_done_flag
                           & (sw_start_pending
                              | (ext_request & ~busy_start_bit));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sw_start_pending <= 1'b0;
        end else if (start_now || low_power) begin
            sw_start_pending <= 1'b0;
        end else if (sw_start_accept) begin
            sw_start_pending <= 1'b1;
        end
    end

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    assign bit_end  = mc_tick & (state == ACS_CONVERT)
                    & (bit_phase == `ACS_BIT_LAST_PHASE);
    assign done_set = bit_end & (conv_cycle == `ACS_LAST_MCYCLE);
    assign next_sar = (cmp_level ? sar : (sar & ~trial_mask))
                    | {1'b0, trial_mask[9:1]};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state      <= ACS_IDLE;
            conv_cycle <= 6'h00;
            bit_phase  <= 2'h0;
        end else if (low_power) begin
            state      <= ACS_IDLE;
            conv_cycle <= 6'h00;
            bit_phase  <= 2'h0;
        end else if (mc_tick) begin
            case (state)
                ACS_IDLE: begin
                    if (start_now) begin
                        state      <= ACS_INIT;
                        conv_cycle <= 6'h00;
                    end
                end
                ACS_INIT: begin
                    conv_cycle <= conv_cycle + 6'h01;
                    if (conv_cycle == `ACS_INIT_END) begin
                        state <= ACS_SAMPLE;
                    end
                end
                ACS_SAMPLE: begin
                    conv_cycle <= conv_cycle + 6'h01;
                    if (conv_cycle == `ACS_SAMPLE_END) begin
                        state     <= ACS_CONVERT;
                        bit_phase <= 2'h0;
                    end
                end
                ACS_CONVERT: begin
                    bit_phase <= bit_phase + 2'h1;
                    if (done_set) begin
                        state      <= ACS_IDLE;
                        conv_cycle <= 6'h00;
                    end else begin
                        conv_cycle <= conv_cycle + 6'h01;
                    end
                end
                default: begin
                    state <= ACS_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // successive approximation register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sar        <= `ACS_RESULT_RESET;
            trial_mask <= `ACS_RESULT_RESET;
        end else if (low_power) begin
            sar        <= `ACS_RESULT_RESET;
            trial_mask <= `ACS_RESULT_RESET;
        end else if (mc_tick && state == ACS_SAMPLE && conv_cycle == `ACS_SAMPLE_END) begin
            sar        <= 10'h200;
            trial_mask <= 10'h200;
        end else if (bit_end) begin
            sar        <= next_sar;
            trial_mask <= {1'b0, trial_mask[9:1]};
        end
    end

    // ************************************************************
    // analog side outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sample_enable <= 1'b0;
            dac_code      <= `ACS_RESULT_RESET;
        end else begin
            sample_enable <= (state == ACS_SAMPLE) & ~low_power;
            dac_code      <= sar;
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            conversion_done_flag <= 1'b0;
        end else if (done_set) begin
            conversion_done_flag <= 1'b1;
        end else if (done_clear) begin
            conversion_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_start_bit <= 1'b0;
        end else if (done_set || low_power) begin
            busy_start_bit <= 1'b0;
        end else if (sw_start_accept) begin
            busy_start_bit <= 1'b1;
        end else if (mc_tick && state == ACS_INIT && conv_cycle == 6'h00) begin
            busy_start_bit <= 1'b1;
        end
    end

    // ************************************************************
    // result and control storage
    // ************************************************************
    // result only loads at completion, so a set flag freezes it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_high_reg <= 8'h00;
            result_low      <= 2'h0;
        end else if (done_set) begin
            result_high_reg <= next_sar[9:2];
            result_low      <= next_sar[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            external_start_enable <= 1'b0;
            channel_select        <= 3'h0;
        end else if (wr_ctrl) begin
            external_start_enable <= reg_wdata[`ACS_EXT_EN_BIT];
            if (!conversion_done_flag && !busy_start_bit) begin
                channel_select <= reg_wdata[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
            end
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == `ACS_CTRL_ADDR) begin
            reg_rdata <= {result_low, external_start_enable, conversion_done_flag,
                          busy_start_bit, channel_select};
        end else if (reg_rd && reg_addr == `ACS_RESULT_HIGH_ADDR) begin
            reg_rdata <= result_high_reg;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tick_since_start <= 6'h00;
        end else if (start_now) begin
            tick_since_start <= 6'h00;
        end else if (mc_tick && state != ACS_IDLE) begin
            tick_since_start <= tick_since_start + 6'h01;
        end
    end

    chk_conv_length: assert property (@(posedge clk) disable iff (!reset_n)
        done_set |-> tick_since_start == 6'd49)
        else $error("conversion length is not fifty machine cycles");

    chk_busy_init: assert property (@(posedge clk) disable iff (!reset_n)
        (mc_tick && state == ACS_INIT && conv_cycle == 6'h00 && !low_power)
        |=> busy_start_bit && state == ACS_INIT)
        else $error("busy not set after first initiation cycle");

    chk_sample_window: assert property (@(posedge clk) disable iff (!reset_n)
        sample_enable |-> $past(state) == ACS_SAMPLE && conv_cycle >= 6'd2
                          && conv_cycle <= 6'd10)
        else $error("sampling outside its eight cycle window");

    chk_bit_rate: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ACS_CONVERT && $past(state) == ACS_CONVERT
         && !$stable(trial_mask) && !low_power)
        |-> $past(mc_tick) && $past(bit_phase) == 2'h3)
        else $error("result bit resolved off the four cycle boundary");

    chk_result_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (conversion_done_flag && $past(conversion_done_flag))
        |-> $stable(result_high_reg) && $stable(result_low))
        else $error("result changed while completion flag set");

    chk_done_hw_only: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(conversion_done_flag) |-> $past(done_set))
        else $error("completion flag set without a finished conversion");

    chk_busy_with_done: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(conversion_done_flag) |-> $fell(busy_start_bit))
        else $error("busy not cleared together with completion");

    chk_abort_lowpow: assert property (@(posedge clk) disable iff (!reset_n)
        low_power |=> state == ACS_IDLE && !busy_start_bit ##1 !sample_enable)
        else $error("low power entry did not abort conversion");

    chk_chan_locked: assert property (@(posedge clk) disable iff (!reset_n)
        (conversion_done_flag || busy_start_bit) |=> $stable(channel_select))
        else $error("channel changed while busy or complete");

    chk_no_restart: assert property (@(posedge clk) disable iff (!reset_n)
        (state != ACS_IDLE && !low_power && !done_set)
        |-> !start_now ##1 (state != ACS_IDLE && conv_cycle >= $past(conv_cycle)))
        else $error("start accepted during a running conversion");

    chk_ext_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (start_now && !sw_start_pending) |-> external_start_enable)
        else $error("pin start while external start disabled");

endmodule

// ---- tb/acs_analog_model.sv ----
`timescale 1ns/10ps

// ****************************************************************
// analog inputs and comparator
// ****************************************************************
module acs_analog_model
    import acs_pkg::*;
(
    input  wire logic [79:0] levels,
    input  wire acs_chan_t   channel_select,
    input  wire logic        sample_enable,
    input  wire logic [9:0]  dac_code,
    output logic             comparator_high
);
    logic [9:0] held;

    // each level equals its code and the comparator counts equality as high, so the result equals the code
    // sample and hold: follows the selected input only while sampling
    always_latch begin
        if (sample_enable) begin
            held <= levels[channel_select*10 +: 10];
        end
    end

    assign comparator_high = (held >= dac_code);
endmodule

// ---- tb/acs_sequencer_tb.sv ----
`timescale 1ns/10ps
`include "acs_params.svh"

module acs_sequencer_tb
    import acs_pkg::*;
;
    logic        clk, reset_n, reg_wr, reg_rd, external_start_pin;
    logic        comparator_high, idle_mode, power_down_mode, sample_enable;
    logic        conversion_done_flag, busy_start_bit;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0]  channel_select;
    logic [9:0]  dac_code;
    logic [79:0] levels;
    int          mismatches, checks_done, cyc, t0, t_samp, samp_cnt, n, ch, m;

    acs_sequencer u_acs_sequencer (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_start_pin(external_start_pin), .comparator_high(comparator_high),
        .idle_mode(idle_mode), .power_down_mode(power_down_mode),
        .channel_select(channel_select), .sample_enable(sample_enable),
        .dac_code(dac_code), .conversion_done_flag(conversion_done_flag),
        .busy_start_bit(busy_start_bit));

    acs_analog_model u_acs_analog_model (.levels(levels), .channel_select(channel_select),
        .sample_enable(sample_enable), .dac_code(dac_code),
        .comparator_high(comparator_high));

    always #25 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sample_enable === 1'b1) begin
            if (samp_cnt == 0) begin
                t_samp <= cyc;
            end
            samp_cnt <= samp_cnt + 1;
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // waits for done (which=1) or busy (which=0) under a bound
    task automatic wait_high(input int which, input int limit, output int k);
        k = 0;
        while ((which ? conversion_done_flag : busy_start_bit) !== 1'b1) begin
            @(posedge clk);
            #1;
            k++;
            if (k > limit) begin
                mismatches++;
                $display("BAD wait expected %0d seen timeout", which);
                complete_run();
            end
        end
    endtask

    task automatic check_result(input int c);
        logic [7:0] lo, hi;
        rd(`ACS_CTRL_ADDR, lo);
        rd(`ACS_RESULT_HIGH_ADDR, hi);
        check("result", {6'h00, levels[c*10 +: 10]}, {6'h00, hi, lo[7:6]});
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        external_start_pin = 1'b0;
        idle_mode = 1'b0;
        power_down_mode = 1'b0;
        cyc = 0;
        samp_cnt = 0;
        // levels stay fixed while any conversion samples them
        levels = {10'h30c, 10'h0f3, 10'h1fe, 10'h201, 10'h2aa, 10'h155, 10'h3ff, 10'h000};
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(`ACS_CTRL_ADDR, d);
        check("ctrl reset", 16'h0000, {8'h00, d});
        rd(`ACS_RESULT_HIGH_ADDR, d);
        check("result reset", 16'h0000, {8'h00, d});
        rd(8'h00, d);
        check("unmapped read", 16'h0000, {8'h00, d});
        wr(`ACS_CTRL_ADDR, 8'hd0);
        wr(8'h00, 8'hff);
        rd(`ACS_CTRL_ADDR, d);
        check("ctrl after writes", 16'h0000, {8'h00, d});
        for (ch = 0; ch < 8; ch++) begin
            wr(`ACS_CTRL_ADDR, 8'h08 | 8'(ch));
            #1;
            t0 = cyc;
            samp_cnt = 0;
            check("channel", 16'(ch), {13'h0000, channel_select});
            repeat (40) @(posedge clk);
            wr(`ACS_CTRL_ADDR, {5'h00, ~3'(ch)});
            wr(`ACS_CTRL_ADDR, {5'h01, ~3'(ch)});
            #1;
            check("busy kept", 16'h0001, {15'h0000, busy_start_bit});
            check("channel kept", 16'(ch), {13'h0000, channel_select});
            wait_high(1, 700, n);
            check("time ok", 16'h0001, 16'((cyc - t0) >= 601 && (cyc - t0) <= 612));
            check("sample to done", 16'd575, 16'(cyc - t_samp));
            check("sample length", 16'd96, 16'(samp_cnt));
            check("busy at done", 16'h0000, {15'h0000, busy_start_bit});
            check_result(ch);
            wr(`ACS_CTRL_ADDR, 8'h00 | 8'(ch));
        end
        wr(`ACS_CTRL_ADDR, 8'h0b);
        wait_high(1, 700, n);
        wr(`ACS_CTRL_ADDR, 8'h38);
        external_start_pin <= 1'b1;
        idle_mode <= 1'b1;
        repeat (36) @(posedge clk);
        external_start_pin <= 1'b0;
        idle_mode <= 1'b0;
        #1;
        check("blocked start", 16'h0003, {14'h0000, conversion_done_flag, ~busy_start_bit});
        check_result(3);
        wr(`ACS_CTRL_ADDR, 8'h08);
        #1;
        check("restart", 16'h000b, {12'h000, busy_start_bit, channel_select});
        wait_high(1, 700, n);
        check_result(3);
        wr(`ACS_CTRL_ADDR, 8'h00);
        external_start_pin <= 1'b1;
        repeat (48) @(posedge clk);
        external_start_pin <= 1'b0;
        #1;
        check("pin disabled", 16'h0000, {15'h0000, busy_start_bit});
        wr(`ACS_CTRL_ADDR, 8'h20);
        repeat (12) @(posedge clk);
        external_start_pin <= 1'b1;
        wait_high(0, 40, n);
        @(posedge clk);
        external_start_pin <= 1'b0;
        wait_high(1, 700, n);
        check_result(0);
        for (m = 0; m < 2; m++) begin
            wr(`ACS_CTRL_ADDR, 8'h08);
            repeat (100) @(posedge clk);
            idle_mode <= (m == 0);
            power_down_mode <= (m == 1);
            repeat (2) @(posedge clk);
            #1;
            check("abort busy", 16'h0000, {15'h0000, busy_start_bit});
            repeat (600) @(posedge clk);
            idle_mode <= 1'b0;
            power_down_mode <= 1'b0;
            #1;
            check("abort done", 16'h0000, {15'h0000, conversion_done_flag});
        end
        complete_run();
    end
endmodule
